// [wakeup_timer_compare_status.sv]
// Wake-up timer interval, compare fields, interrupt enables and status
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module wakeup_timer_compare_status (
    input wire logic clk,
    input wire logic srst,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic timer_enable,
    input wire logic free_run_mode,
    input wire logic [31:0] compare_field_a,
    input wire logic count_value_low_read,
    input wire logic count_value_high_read,
    input wire logic [wakeup_timer_pkg::FLAG_W-1:0] irq_clear,
    output logic [31:0] count_value,
    output logic wake_request,
    output logic irq
);
    import wakeup_timer_pkg::*;

    regs_s s;
    regs_s next_s;
    logic [4:0] flag_set;
    logic [EVENT_W-1:0] events;
    logic wr_int;
    logic wr_ien;
    logic sync_done;
    logic [31:0] status_word;
    logic addr_mapped;

    slow_link link ();

    slow_counter_core u_core (
        .clk(clk),
        .srst(srst),
        .link(link)
    );

    assign link.run_req = timer_enable;
    assign link.free_run = free_run_mode;
    assign link.cmp = {s.cmp_d, s.cmp_c, s.cmp_b, compare_field_a};

    // Compare and rollover hits gated by their enables
    assign flag_set[3:0] = link.hit & s.ien[3:0];
    assign flag_set[ROLL_BIT] = link.roll & s.ien[ROLL_BIT];

    assign wr_int = reg_write && (reg_addr == ADDR_INTERVAL);
    assign wr_ien = reg_write && (reg_addr == ADDR_IRQ_ENABLE);

    // Handover completes in the cycle the applied run state catches up with the enable
    assign sync_done = s.sync_pend & (link.run == s.en_d) & (timer_enable == s.en_d);

    // Newly visible flags and completion of an enable handover raise events
    assign events = {sync_done, (s.raw & ~s.flag)};

    // Status word built from its field positions; bit 5 and the upper bits stay zero
    always_comb
    begin
        status_word = 32'h0;
        status_word[FLAG_W-1:0] = s.flag;
        status_word[ST_WAKE] = s.wake;
        status_word[ST_FREEZE] = s.freeze;
        status_word[ST_SYNC_PEND] = s.sync_pend;
    end

    // Decode of the addresses this block answers; all others read zero
    always_comb
    begin
        case (reg_addr)
            ADDR_INTERVAL, ADDR_CMP_B_LOW, ADDR_CMP_B_HIGH, ADDR_CMP_C_LOW, ADDR_CMP_C_HIGH,
            ADDR_CMP_D_LOW, ADDR_CMP_D_HIGH, ADDR_IRQ_ENABLE, ADDR_STATUS, ADDR_EVENT_STATUS,
            ADDR_EVENT_MASK:
            begin
                addr_mapped = 1'b1;
            end
            default:
            begin
                addr_mapped = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        next_s = s;
        next_s.rdata = 32'h0;
        next_s.en_d = timer_enable;

        // Handover flag rises on any enable change, falls once applied
        if (timer_enable != s.en_d)
        begin
            next_s.sync_pend = 1'b1;
        end
        else if (link.run == s.en_d)
        begin
            next_s.sync_pend = 1'b0;
        end

        if (count_value_high_read)
        begin
            next_s.freeze = 1'b0;
        end
        else if (count_value_low_read)
        begin
            next_s.freeze = 1'b1;
        end
        if (!s.freeze)
        begin
            next_s.snap = link.count;
        end

        // Clear requests wait for the next slow edge, then restart from the irq_clear requests of that cycle
        if (link.tick)
        begin
            next_s.raw = (s.raw & ~s.clr_pend) | flag_set;
            next_s.clr_pend = irq_clear;
        end
        else
        begin
            next_s.raw = s.raw | flag_set;
            next_s.clr_pend = s.clr_pend | irq_clear;
        end
        next_s.flag = s.raw;
        next_s.wake = |s.raw;

        next_s.ev_status = s.ev_status | events;

        if (reg_write)
        begin
            case (reg_addr)
                ADDR_INTERVAL:
                begin
                    next_s.interval = reg_wdata[INTERVAL_W-1:0];
                end
                ADDR_CMP_B_LOW:
                begin
                    next_s.cmp_b[15:0] = reg_wdata[15:0];
                end
                ADDR_CMP_B_HIGH:
                begin
                    next_s.cmp_b[31:16] = reg_wdata[15:0];
                end
                ADDR_CMP_C_LOW:
                begin
                    next_s.cmp_c[15:0] = reg_wdata[15:0];
                end
                ADDR_CMP_C_HIGH:
                begin
                    next_s.cmp_c[31:16] = reg_wdata[15:0];
                end
                ADDR_CMP_D_LOW:
                begin
                    next_s.cmp_d[15:0] = reg_wdata[15:0];
                end
                ADDR_CMP_D_HIGH:
                begin
                    next_s.cmp_d[31:16] = reg_wdata[15:0];
                end
                ADDR_IRQ_ENABLE:
                begin
                    next_s.ien = reg_wdata[FLAG_W-1:0];
                end
                ADDR_EVENT_STATUS:
                begin
                    // Set wins over a write-one clear in the same cycle
                    next_s.ev_status = (s.ev_status & ~reg_wdata[EVENT_W-1:0]) | events;
                end
                ADDR_EVENT_MASK:
                begin
                    next_s.ev_mask = reg_wdata[EVENT_W-1:0];
                end
                default:
                begin
                    next_s.ev_mask = s.ev_mask;
                end
            endcase
        end

        if (reg_read)
        begin
            case (reg_addr)
                ADDR_INTERVAL:
                begin
                    next_s.rdata = {20'h0, s.interval};
                end
                ADDR_CMP_B_LOW:
                begin
                    next_s.rdata = {16'h0, s.cmp_b[15:0]};
                end
                ADDR_CMP_B_HIGH:
                begin
                    next_s.rdata = {16'h0, s.cmp_b[31:16]};
                end
                ADDR_CMP_C_LOW:
                begin
                    next_s.rdata = {16'h0, s.cmp_c[15:0]};
                end
                ADDR_CMP_C_HIGH:
                begin
                    next_s.rdata = {16'h0, s.cmp_c[31:16]};
                end
                ADDR_CMP_D_LOW:
                begin
                    next_s.rdata = {16'h0, s.cmp_d[15:0]};
                end
                ADDR_CMP_D_HIGH:
                begin
                    next_s.rdata = {16'h0, s.cmp_d[31:16]};
                end
                ADDR_IRQ_ENABLE:
                begin
                    next_s.rdata = {27'h0, s.ien};
                end
                ADDR_STATUS:
                begin
                    next_s.rdata = status_word;
                end
                ADDR_EVENT_STATUS:
                begin
                    next_s.rdata = {26'h0, s.ev_status};
                end
                ADDR_EVENT_MASK:
                begin
                    next_s.rdata = {26'h0, s.ev_mask};
                end
                default:
                begin
                    next_s.rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s <= '0;
            s.interval <= RST_INTERVAL;
            s.cmp_b <= RST_CMP_B;
            s.cmp_c <= RST_CMP_C;
            s.cmp_d <= RST_CMP_D;
            s.ien <= RST_IRQ_ENABLE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign count_value = s.snap;
    assign wake_request = s.wake;
    assign irq = |(s.ev_status & s.ev_mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence seq_hit_b;
        link.hit[1] && s.ien[1];
    endsequence

    sequence seq_flag_b_seen;
        s.raw[1] ##1 s.flag[1];
    endsequence

    sequence seq_low_read_open;
        count_value_low_read && !count_value_high_read && !s.freeze;
    endsequence

    sequence seq_frozen;
        s.freeze;
    endsequence

    sequence seq_clear_c_due;
        link.tick && s.clr_pend[2] && !flag_set[2];
    endsequence

    sequence seq_flag_c_gone;
        !s.raw[2] ##1 !s.flag[2];
    endsequence

    // Register access
    a_interval_reserved: assert property (reg_read && reg_addr == ADDR_INTERVAL
        |=> reg_rdata[31:12] == 20'h0 && reg_rdata[11:0] == $past(s.interval))
        else $error("interval read shows reserved bits or wrong value");
    a_interval_write: assert property (wr_int
        |=> s.interval == $past(reg_wdata[INTERVAL_W-1:0]))
        else $error("interval write did not land");
    a_status_reserved: assert property (reg_read && reg_addr == ADDR_STATUS
        |=> reg_rdata[31:9] == 23'h0 && reg_rdata[5] == 1'b0)
        else $error("status reserved bits not zero");
    a_status_fields: assert property (reg_read && reg_addr == ADDR_STATUS
        |=> reg_rdata[ST_SYNC_PEND] == $past(s.sync_pend)
            && reg_rdata[ST_FREEZE] == $past(s.freeze)
            && reg_rdata[ST_WAKE] == $past(s.wake))
        else $error("status field out of place");
    a_unmapped_read: assert property (reg_read && !addr_mapped |=> reg_rdata == 32'h0)
        else $error("unmapped address read not zero");
    a_ien_write: assert property (wr_ien |=> s.ien == $past(reg_wdata[FLAG_W-1:0]))
        else $error("enable register write did not land");
    a_cmp_high_write: assert property (reg_write && reg_addr == ADDR_CMP_B_HIGH
        |=> s.cmp_b[31:16] == $past(reg_wdata[15:0]))
        else $error("upper compare word write did not land");
    a_cmp_low_write: assert property (reg_write && reg_addr == ADDR_CMP_D_LOW
        |=> s.cmp_d[15:0] == $past(reg_wdata[15:0]))
        else $error("lower compare word write did not land");
    // Enable handover and freeze
    a_enable_change: assert property (timer_enable != s.en_d |=> s.sync_pend)
        else $error("enable change did not raise handover flag");
    a_enable_synced: assert property (s.sync_pend && link.run == s.en_d
        && timer_enable == s.en_d |=> !s.sync_pend)
        else $error("handover flag stayed after slow domain applied enable");
    a_sync_event: assert property (sync_done |=> s.ev_status[EV_SYNC_DONE])
        else $error("handover completion did not raise its event");
    a_freeze_steps: assert property (seq_low_read_open
        |=> s.freeze && count_value == $past(link.count))
        else $error("low count read did not freeze value");
    a_freeze_hold: assert property (seq_frozen |=> count_value == $past(count_value))
        else $error("frozen count value moved");
    a_freeze_release: assert property (count_value_high_read |=> !s.freeze)
        else $error("high count read did not release freeze");
    // Flags, clears and wake request
    a_match_flag: assert property (seq_hit_b |=> seq_flag_b_seen)
        else $error("enabled match on field B did not reach status");
    a_flag_sticky: assert property (s.raw[0] && !s.clr_pend[0] && !(|irq_clear)
        |=> s.raw[0])
        else $error("compare flag dropped without clear request");
    a_clear_collect: assert property (!link.tick && irq_clear[3] |=> s.clr_pend[3])
        else $error("clear request was not held for the slow edge");
    a_clear_capture: assert property (link.tick |=> s.clr_pend == $past(irq_clear))
        else $error("clear requests not restarted at the slow edge");
    a_clear_applies: assert property (seq_clear_c_due |=> seq_flag_c_gone)
        else $error("clear request did not clear flag");
    a_flag_follow: assert property (s.raw != s.flag |=> s.flag == $past(s.raw))
        else $error("status flags did not follow the synchronising stage");
    a_wake_follow: assert property (s.raw != 5'h0 |=> wake_request)
        else $error("pending flag did not raise wake request");
    a_roll_gated: assert property (link.roll && !s.ien[ROLL_BIT] && !s.raw[ROLL_BIT]
        |=> !s.raw[ROLL_BIT])
        else $error("rollover flag set while disabled");
    a_roll_set: assert property (link.roll && s.ien[ROLL_BIT] |=> s.raw[ROLL_BIT])
        else $error("enabled rollover did not set its flag");
endmodule
`default_nettype wire

// [wakeup_timer_pkg.sv]
// Constants, register map and state types for the wake-up timer status block
// Function
// - Interval register holds a 12-bit wake-up interval; upper twenty bits reserved.
// - Compare fields B to D are 32 bits, split into low and high 16-bit words; field A is a 32-bit input.
// - Enable bit 4 allows rollover interrupt, free running mode only, default off.
// - Enable bits 0 to 3 allow compare interrupts A to D, default off.
// - Status bit 8 rises on enable change, falls once the slow domain applied it.
// - Status bit 7 sets on low count read, clears on high count read.
// - Status bit 6 shows a wake request while any slow-domain flag is pending.
// - Rollover flag sets when enabled and the free running counter is all ones.
// - Status bits 0 to 3 set on compare match A to D when enabled.
// - Compare flags clear only through a one on the irq_clear input.
// - Periodic mode counts up to field D; free running wraps all ones to zero.
// - A clear bit clears its flag after synchronisation; pending clears then reload from irq_clear.
package wakeup_timer_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int SLOW_HZ = 32768;
    localparam logic [8:0] SLOW_TICK_CYCLES = 9'(CLK_HZ / SLOW_HZ);

    localparam logic [31:0] ADDR_INTERVAL = 32'h4000250c;
    localparam logic [31:0] ADDR_CMP_B_LOW = 32'h40002510;
    localparam logic [31:0] ADDR_CMP_B_HIGH = 32'h40002514;
    localparam logic [31:0] ADDR_CMP_C_LOW = 32'h40002518;
    localparam logic [31:0] ADDR_CMP_C_HIGH = 32'h4000251c;
    localparam logic [31:0] ADDR_CMP_D_LOW = 32'h40002520;
    localparam logic [31:0] ADDR_CMP_D_HIGH = 32'h40002524;
    localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h40002528;
    localparam logic [31:0] ADDR_STATUS = 32'h4000252c;
    localparam logic [31:0] ADDR_EVENT_STATUS = 32'h40002544;
    localparam logic [31:0] ADDR_EVENT_MASK = 32'h40002548;

    localparam logic [11:0] RST_INTERVAL = 12'h0c8;
    localparam logic [31:0] RST_CMP_B = 32'h00001fff;
    localparam logic [31:0] RST_CMP_C = 32'h00002fff;
    localparam logic [31:0] RST_CMP_D = 32'h00003fff;
    localparam logic [4:0] RST_IRQ_ENABLE = 5'h00;

    localparam int INTERVAL_W = 12;
    localparam int FLAG_W = 5;
    localparam int EVENT_W = 6;
    localparam int ROLL_BIT = 4;
    localparam int ST_WAKE = 6;
    localparam int ST_FREEZE = 7;
    localparam int ST_SYNC_PEND = 8;
    localparam int EV_SYNC_DONE = 5;

    typedef struct packed {
        logic [8:0] div;
        logic tick;
        logic run;
        logic [31:0] count;
        logic [3:0] hit;
        logic roll;
    } core_s;

    typedef struct packed {
        logic en_d;
        logic sync_pend;
        logic freeze;
        logic [11:0] interval;
        logic [31:0] cmp_b;
        logic [31:0] cmp_c;
        logic [31:0] cmp_d;
        logic [4:0] ien;
        logic [4:0] raw;
        logic [4:0] clr_pend;
        logic [4:0] flag;
        logic wake;
        logic [31:0] snap;
        logic [5:0] ev_status;
        logic [5:0] ev_mask;
        logic [31:0] rdata;
    } regs_s;
endpackage

// [slow_link.sv]
// Signals between the register side and the slow counting core
`timescale 1ns/10ps
`default_nettype none
interface slow_link;
    logic run_req;
    logic free_run;
    logic [3:0][31:0] cmp;
    logic tick;
    logic run;
    logic [31:0] count;
    logic [3:0] hit;
    logic roll;

    modport core (input run_req, free_run, cmp, output tick, run, count, hit, roll);
    modport host (output run_req, free_run, cmp, input tick, run, count, hit, roll);
endinterface
`default_nettype wire

// [slow_counter_core.sv]
// Slow-rate counter: tick divider, 32-bit count, compare and rollover pulses
`timescale 1ns/10ps
`default_nettype none
module slow_counter_core (
    input wire logic clk,
    input wire logic srst,
    slow_link.core link
);
    import wakeup_timer_pkg::*;

    core_s s;
    core_s next_s;
    logic [3:0] eq;

    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_cmp
            assign eq[i] = (s.count == link.cmp[i]);
        end
    endgenerate

    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        next_s.hit = 4'h0;
        next_s.roll = 1'b0;
        if (s.div == SLOW_TICK_CYCLES - 9'h001)
        begin
            next_s.div = 9'h000;
            next_s.tick = 1'b1;
        end
        else
        begin
            next_s.div = s.div + 9'h001;
        end
        if (s.tick)
        begin
            next_s.run = link.run_req;
            if (s.run)
            begin
                next_s.hit = eq;
                next_s.roll = link.free_run && (s.count == 32'hffffffff);
                if (link.free_run)
                begin
                    next_s.count = s.count + 32'h00000001;
                end
                else if (s.count >= link.cmp[3])
                begin
                    next_s.count = 32'h00000000;
                end
                else
                begin
                    next_s.count = s.count + 32'h00000001;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign link.tick = s.tick;
    assign link.run = s.run;
    assign link.count = s.count;
    assign link.hit = s.hit;
    assign link.roll = s.roll;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence seq_periodic_end;
        s.tick && s.run && !link.free_run && (s.count >= link.cmp[3]);
    endsequence

    a_periodic_restart: assert property (seq_periodic_end |=> s.count == 32'h0)
        else $error("periodic count did not restart after field D");
    a_free_wrap: assert property (s.tick && s.run && link.free_run
        && s.count == 32'hffffffff |=> s.count == 32'h0 && s.roll)
        else $error("free running count did not wrap with rollover");
    a_roll_free_only: assert property (s.roll |-> $past(link.free_run))
        else $error("rollover pulse outside free running mode");
endmodule
`default_nettype wire

// [wakeup_timer_compare_status_tb_top.sv]
// Self-checking bench for the wake-up timer compare and status block
`timescale 1ns/10ps
`default_nettype none
module wakeup_timer_compare_status_tb_top import wakeup_timer_pkg::*;;
    typedef struct packed {
        logic [31:0] addr;
        logic wr;
        logic [31:0] wd;
        logic [31:0] exp;
    } row_s;

    logic clk;
    logic srst;
    logic [31:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [31:0] reg_rdata;
    logic timer_enable;
    logic free_run_mode;
    logic [31:0] compare_field_a;
    logic count_value_low_read;
    logic count_value_high_read;
    logic [FLAG_W-1:0] irq_clear;
    logic [31:0] count_value;
    logic wake_request;
    logic irq;
    int error_cnt = 0;
    int checks_done = 0;
    logic [31:0] d;
    logic [31:0] held;
    logic [31:0] top;

    // Reset reads first, then writes with the read-back each should give
    row_s rows [0:20] = '{
        '{ADDR_INTERVAL, 1'b0, 32'h0, 32'h000000c8},
        '{ADDR_CMP_B_LOW, 1'b0, 32'h0, 32'h00001fff},
        '{ADDR_CMP_B_HIGH, 1'b0, 32'h0, 32'h00000000},
        '{ADDR_CMP_C_LOW, 1'b0, 32'h0, 32'h00002fff},
        '{ADDR_CMP_C_HIGH, 1'b0, 32'h0, 32'h00000000},
        '{ADDR_CMP_D_LOW, 1'b0, 32'h0, 32'h00003fff},
        '{ADDR_CMP_D_HIGH, 1'b0, 32'h0, 32'h00000000},
        '{ADDR_IRQ_ENABLE, 1'b0, 32'h0, 32'h00000000},
        '{ADDR_STATUS, 1'b0, 32'h0, 32'h00000000},
        '{32'h40002530, 1'b0, 32'h0, 32'h00000000},
        '{ADDR_INTERVAL, 1'b1, 32'hffffffff, 32'h00000fff},
        '{ADDR_CMP_B_LOW, 1'b1, 32'hffff0003, 32'h00000003},
        '{ADDR_CMP_B_HIGH, 1'b1, 32'h00010000, 32'h00000000},
        '{ADDR_CMP_C_LOW, 1'b1, 32'h00000004, 32'h00000004},
        '{ADDR_CMP_C_HIGH, 1'b1, 32'h00000000, 32'h00000000},
        '{ADDR_CMP_D_LOW, 1'b1, 32'h00000006, 32'h00000006},
        '{ADDR_CMP_D_HIGH, 1'b1, 32'h00000000, 32'h00000000},
        '{ADDR_STATUS, 1'b1, 32'hffffffff, 32'h00000000},
        '{32'h40002530, 1'b1, 32'h00001234, 32'h00000000},
        '{ADDR_IRQ_ENABLE, 1'b1, 32'hffffffe0, 32'h00000000},
        '{ADDR_IRQ_ENABLE, 1'b1, 32'hffffffef, 32'h0000000f}
    };

    wakeup_timer_compare_status wakeup_timer_compare_status_i (
        .clk(clk),
        .srst(srst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .timer_enable(timer_enable),
        .free_run_mode(free_run_mode),
        .compare_field_a(compare_field_a),
        .count_value_low_read(count_value_low_read),
        .count_value_high_read(count_value_high_read),
        .irq_clear(irq_clear),
        .count_value(count_value),
        .wake_request(wake_request),
        .irq(irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic end_sim();
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    // Read data is registered and stands only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic pulse(input logic [1:0] sel, input logic [4:0] bits);
        @(posedge clk);
        count_value_low_read <= sel[0];
        count_value_high_read <= sel[1];
        irq_clear <= bits;
        @(posedge clk);
        count_value_low_read <= 1'b0;
        count_value_high_read <= 1'b0;
        irq_clear <= 5'h00;
    endtask

    // Reads status until the masked bits match, within a bounded count
    task automatic poll(input logic [31:0] mask, input logic [31:0] val, input int n);
        int k;
        k = 0;
        rd(ADDR_STATUS, d);
        while ((d & mask) !== val && k < n)
        begin
            rd(ADDR_STATUS, d);
            k++;
        end
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    initial
    begin
        srst = 1'b1;
        reg_addr = 32'h0;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        timer_enable = 1'b0;
        free_run_mode = 1'b1;
        compare_field_a = 32'h00000002;
        count_value_low_read = 1'b0;
        count_value_high_read = 1'b0;
        irq_clear = 5'h00;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1;
        check_word(count_value, 32'h0);
        check_bit(irq, 1'b0);
        // Fields are set while the timer and their enables are off
        for (int i = 0; i < 21; i++)
        begin
            if (rows[i].wr)
                wr(rows[i].addr, rows[i].wd);
            rd(rows[i].addr, d);
            check_word(d, rows[i].exp);
        end
        @(posedge clk);
        timer_enable <= 1'b1;
        rd(ADDR_STATUS, d);
        check_bit(d[8], 1'b1);
        poll(32'h100, 32'h0, 400);
        check_bit(d[8], 1'b0);
        poll(32'h00f, 32'h00f, 2500);
        check_word(d & 32'h1f, 32'h0000000f);
        check_bit(wake_request, 1'b1);
        check_bit(d[6], 1'b1);
        wr(ADDR_EVENT_MASK, 32'h0);
        #1;
        check_bit(irq, 1'b0);
        wr(ADDR_EVENT_MASK, 32'h0000000f);
        #1;
        check_bit(irq, 1'b1);
        rd(ADDR_EVENT_STATUS, d);
        check_word(d, 32'h0000002f);
        wr(ADDR_EVENT_STATUS, 32'h0000003f);
        #1;
        check_bit(irq, 1'b0);
        // Flags hold until cleared, and a partial clear leaves the others
        repeat (700) @(posedge clk);
        rd(ADDR_STATUS, d);
        check_word(d & 32'h1f, 32'h0000000f);
        pulse(2'b00, 5'h05);
        poll(32'h00f, 32'h00a, 400);
        check_word(d & 32'h1f, 32'h0000000a);
        check_bit(wake_request, 1'b1);
        pulse(2'b00, 5'h0a);
        poll(32'h00f, 32'h000, 400);
        check_word(d & 32'h1f, 32'h00000000);
        repeat (3) @(posedge clk);
        #1;
        check_bit(wake_request, 1'b0);
        // Freeze holds the snapshot until the high half is read
        pulse(2'b01, 5'h00);
        rd(ADDR_STATUS, d);
        check_bit(d[7], 1'b1);
        held = count_value;
        repeat (700) @(posedge clk);
        #1;
        check_word(count_value, held);
        pulse(2'b10, 5'h00);
        rd(ADDR_STATUS, d);
        check_bit(d[7], 1'b0);
        repeat (700) @(posedge clk);
        #1;
        check_bit(count_value !== held, 1'b1);
        // Periodic mode: disable, change mode, run again
        @(posedge clk);
        timer_enable <= 1'b0;
        poll(32'h100, 32'h0, 400);
        wr(ADDR_IRQ_ENABLE, 32'h0);
        @(posedge clk);
        free_run_mode <= 1'b0;
        @(posedge clk);
        timer_enable <= 1'b1;
        poll(32'h100, 32'h0, 400);
        repeat (700) @(posedge clk);
        top = 32'h0;
        repeat (2500)
        begin
            @(posedge clk);
            #1;
            if (count_value > top)
                top = count_value;
        end
        check_word(top, 32'h00000006);
        // Reset in mid-run brings every register back
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        timer_enable <= 1'b0;
        #1;
        check_word(count_value, 32'h0);
        check_bit(wake_request, 1'b0);
        rd(ADDR_IRQ_ENABLE, d);
        check_word(d, 32'h0);
        rd(ADDR_CMP_D_LOW, d);
        check_word(d, 32'h00003fff);
        end_sim();
    end
endmodule
`default_nettype wire
